// file: inc/eam_pkg.sv
// Package of constants and types for the exclusive access monitor.
package eam_pkg;

   // ---------------------------------------------------------------
   // Operation encodings
   // ---------------------------------------------------------------
   // Width of the operation code presented by the core.
   localparam int OP_W = 3;
   // No exclusive operation this cycle.
   localparam logic [2:0] OP_NONE = 3'h0;
   // Load exclusive word.
   localparam logic [2:0] OP_LOAD_EXCLUSIVE_WORD = 3'h1;
   // Load exclusive halfword.
   localparam logic [2:0] OP_LOAD_EXCLUSIVE_HALF = 3'h2;
   // Load exclusive byte.
   localparam logic [2:0] OP_LOAD_EXCLUSIVE_BYTE = 3'h3;
   // Store exclusive word.
   localparam logic [2:0] OP_STORE_EXCLUSIVE_WORD = 3'h4;
   // Store exclusive halfword.
   localparam logic [2:0] OP_STORE_EXCLUSIVE_HALF = 3'h5;
   // Store exclusive byte.
   localparam logic [2:0] OP_STORE_EXCLUSIVE_BYTE = 3'h6;
   // Clear exclusive.
   localparam logic [2:0] OP_CLEAR_EXCLUSIVE = 3'h7;

   // ---------------------------------------------------------------
   // Access sizes
   // ---------------------------------------------------------------
   // Size codes reported with a tagged access.
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // ---------------------------------------------------------------
   // Reset values and exception states
   // ---------------------------------------------------------------
   // Local tag value after reset.
   localparam logic LOCAL_TAG_RST = 1'b0;

   // State of one exception, encoded 0, 1 and 3.
   typedef enum logic [1:0] {
      EAM_EXC_INACTIVE = 2'h0,
      EAM_EXC_PENDING = 2'h1,
      EAM_EXC_ACTIVE = 2'h3
   } eam_exc_state_type;

endpackage

// file: hw/eam_exc_state.sv
// State tracker for the exceptions seen by the exclusive access monitor.
`timescale 1ns/1ps
`default_nettype none

module eam_exc_state
   import eam_pkg::*;
#(
   parameter int NUM_EXC = 8
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [NUM_EXC-1:0] irq_hw_i,
   input wire logic [NUM_EXC-1:0] irq_sw_i,
   input wire logic [NUM_EXC-1:0] take_i,
   input wire logic [NUM_EXC-1:0] done_i,
   output logic [NUM_EXC-1:0] pending_o,
   output logic [NUM_EXC-1:0] active_o
);

   // State of each exception.
   eam_exc_state_type state_ff [NUM_EXC];
   // Next state of each exception.
   eam_exc_state_type nxt_state [NUM_EXC];
   // Pending and active flags, registered so that each output leaves a flip-flop.
   logic [NUM_EXC-1:0] pending_ff;
   logic [NUM_EXC-1:0] active_ff;
   logic [NUM_EXC-1:0] nxt_pending;
   logic [NUM_EXC-1:0] nxt_active;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Each exception holds exactly one state; requests make it pending.
   always_comb begin
      for (int i = 0; i < NUM_EXC; i++) begin
         nxt_state[i] = state_ff[i];
         case (state_ff[i])
            EAM_EXC_INACTIVE: begin
               // A hardware or software request makes it pending.
               if (irq_hw_i[i] || irq_sw_i[i]) begin // R12
                  nxt_state[i] = EAM_EXC_PENDING; // R11
               end
            end
            EAM_EXC_PENDING: begin
               // The core services the waiting exception.
               if (take_i[i]) begin
                  nxt_state[i] = EAM_EXC_ACTIVE;
               end
            end
            EAM_EXC_ACTIVE: begin
               // Return from the handler leaves it inactive.
               if (done_i[i]) begin
                  nxt_state[i] = EAM_EXC_INACTIVE; // R10
               end
            end
            default: begin
               nxt_state[i] = EAM_EXC_INACTIVE;
            end
         endcase
         // Flags follow the next state so they match the state register.
         nxt_pending[i] = (nxt_state[i] == EAM_EXC_PENDING);
         nxt_active[i] = (nxt_state[i] == EAM_EXC_ACTIVE);
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   // Registers the states; reset leaves all inactive.
   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < NUM_EXC; i++) begin
         if (srst_i) begin
            state_ff[i] <= EAM_EXC_INACTIVE; // R13
            pending_ff[i] <= 1'b0;
            active_ff[i] <= 1'b0;
         end else begin
            state_ff[i] <= nxt_state[i];
            pending_ff[i] <= nxt_pending[i];
            active_ff[i] <= nxt_active[i];
         end
      end
   end

   // State flags, each straight from its own register.
   assign pending_o = pending_ff;
   assign active_o = active_ff;

endmodule

`default_nettype wire

// file: hw/eam_monitor.sv
// Exclusive access monitor with local and global tags and exception states.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01: Exclusive load sets the local tag.
// R02: Global tag kept per addressed location.
// R03: Clear exclusive removes the local tag.
// R04: Any exclusive store removes local tag; the code clears it only on stores from CPU index 0.
// R05: Any exception removes the local tag.
// R06: Clear exclusive leaves global tags untouched.
// R07: Store or exception clears all own tags.
// R08: Exclusive store returns a success status.
// R09: Word, halfword and byte exclusive loads.
// R10: Each exception holds one state; inactive.
// R11: Pending means waiting for service.
// R12: Hardware or software request makes pending.
// R13: Reset clears tag, exceptions start inactive.
module eam_monitor
   import eam_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int NUM_CPU = 2,
   parameter int CPU_W = 1,
   parameter int NUM_EXC = 8
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic op_valid_i,
   input wire logic [OP_W-1:0] op_code_i,
   input wire logic [ADDR_W-1:0] op_addr_i,
   input wire logic [CPU_W-1:0] op_cpu_i,
   input wire logic [NUM_EXC-1:0] irq_hw_i,
   input wire logic [NUM_EXC-1:0] irq_sw_i,
   input wire logic [NUM_EXC-1:0] exc_take_i,
   input wire logic [NUM_EXC-1:0] exc_done_i,
   output logic local_tag_o,
   output logic [ADDR_W-1:0] tag_addr_o,
   output logic [1:0] tag_size_o,
   output logic [NUM_CPU-1:0] global_tag_o,
   output logic store_done_o,
   output logic store_fail_o,
   output logic [NUM_EXC-1:0] exc_pending_o,
   output logic [NUM_EXC-1:0] exc_active_o
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // True for any of the three exclusive load sizes.
   function automatic logic is_load(input logic [OP_W-1:0] op);
      is_load = (op == OP_LOAD_EXCLUSIVE_WORD) || (op == OP_LOAD_EXCLUSIVE_HALF)
         || (op == OP_LOAD_EXCLUSIVE_BYTE);
   endfunction

   // True for any of the three exclusive store sizes.
   function automatic logic is_store(input logic [OP_W-1:0] op);
      is_store = (op == OP_STORE_EXCLUSIVE_WORD) || (op == OP_STORE_EXCLUSIVE_HALF)
         || (op == OP_STORE_EXCLUSIVE_BYTE);
   endfunction

   // Access size of an exclusive operation.
   function automatic logic [1:0] op_size(input logic [OP_W-1:0] op);
      case (op)
         OP_LOAD_EXCLUSIVE_BYTE, OP_STORE_EXCLUSIVE_BYTE: op_size = SIZE_BYTE;
         OP_LOAD_EXCLUSIVE_HALF, OP_STORE_EXCLUSIVE_HALF: op_size = SIZE_HALF;
         default: op_size = SIZE_WORD;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Local monitor state
   // ---------------------------------------------------------------
   // Local tag of the processor owning this monitor, CPU index 0.
   logic local_tag_ff;
   logic nxt_local_tag;
   // Address and size recorded by the last own exclusive load.
   logic [ADDR_W-1:0] tag_addr_ff;
   logic [ADDR_W-1:0] nxt_tag_addr;
   logic [1:0] tag_size_ff;
   logic [1:0] nxt_tag_size;
   // Global tag per processor, each over its own address.
   logic [NUM_CPU-1:0] gtag_ff;
   logic [NUM_CPU-1:0] nxt_gtag;
   logic [ADDR_W-1:0] gaddr_ff [NUM_CPU];
   logic [ADDR_W-1:0] nxt_gaddr [NUM_CPU];
   // Store result registers.
   logic store_done_ff;
   logic nxt_store_done;
   logic store_fail_ff;
   logic nxt_store_fail;
   // Any exception taken this cycle.
   logic exc_any;
   // Decoded operation strobes.
   logic do_load;
   logic do_store;
   logic do_clear;
   // Local operation, i.e. from the owning processor.
   logic own_op;
   // Store passes both local and global checks.
   logic store_ok;

   // Operation decode.
   always_comb begin
      exc_any = |exc_take_i;
      do_load = op_valid_i && is_load(op_code_i); // R09
      do_store = op_valid_i && is_store(op_code_i);
      do_clear = op_valid_i && (op_code_i == OP_CLEAR_EXCLUSIVE);
      own_op = (op_cpu_i == '0);
      store_ok = local_tag_ff && (tag_addr_ff == op_addr_i)
         && gtag_ff[op_cpu_i] && (gaddr_ff[op_cpu_i] == op_addr_i);
   end

   // ---------------------------------------------------------------
   // Next-state logic of the tags
   // ---------------------------------------------------------------
   // An exception clears own tags; else the operation decides.
   always_comb begin
      nxt_local_tag = local_tag_ff;
      nxt_tag_addr = tag_addr_ff;
      nxt_tag_size = tag_size_ff;
      nxt_gtag = gtag_ff;
      nxt_store_done = 1'b0;
      nxt_store_fail = 1'b0;
      for (int c = 0; c < NUM_CPU; c++) begin
         nxt_gaddr[c] = gaddr_ff[c];
      end
      if (exc_any) begin
         // An exception drops local and own global tags.
         nxt_local_tag = 1'b0; // R05
         nxt_gtag[0] = 1'b0; // R07
      end else if (do_load) begin
         // Tag the location globally for the issuing processor.
         nxt_gtag[op_cpu_i] = 1'b1; // R02
         nxt_gaddr[op_cpu_i] = op_addr_i;
         if (own_op) begin
            // Exclusive load by this processor sets the local tag.
            nxt_local_tag = 1'b1; // R01
            nxt_tag_addr = op_addr_i;
            nxt_tag_size = op_size(op_code_i);
         end
      end else if (do_store) begin
         // Report the result, then drop the issuer's tags.
         nxt_store_done = 1'b1; // R08
         nxt_store_fail = !(store_ok && own_op) && !(!own_op && gtag_ff[op_cpu_i]
            && gaddr_ff[op_cpu_i] == op_addr_i);
         nxt_gtag[op_cpu_i] = 1'b0; // R07
         if (own_op) begin
            nxt_local_tag = 1'b0; // R04
         end
         // A successful write steals the location from other tags.
         if (!nxt_store_fail) begin
            for (int c = 0; c < NUM_CPU; c++) begin
               if (gaddr_ff[c] == op_addr_i) begin
                  nxt_gtag[c] = 1'b0;
               end
            end
         end
      end else if (do_clear && own_op) begin
         // Clear exclusive touches the local tag only.
         nxt_local_tag = 1'b0; // R03 R06
      end
   end

   // ---------------------------------------------------------------
   // Tag registers
   // ---------------------------------------------------------------
   // Registers the tags and the store result.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         local_tag_ff <= LOCAL_TAG_RST; // R13
         tag_addr_ff <= '0;
         tag_size_ff <= SIZE_WORD;
         gtag_ff <= '0;
         store_done_ff <= 1'b0;
         store_fail_ff <= 1'b0;
         for (int c = 0; c < NUM_CPU; c++) begin
            gaddr_ff[c] <= '0;
         end
      end else begin
         local_tag_ff <= nxt_local_tag;
         tag_addr_ff <= nxt_tag_addr;
         tag_size_ff <= nxt_tag_size;
         gtag_ff <= nxt_gtag;
         store_done_ff <= nxt_store_done;
         store_fail_ff <= nxt_store_fail;
         for (int c = 0; c < NUM_CPU; c++) begin
            gaddr_ff[c] <= nxt_gaddr[c];
         end
      end
   end

   // ---------------------------------------------------------------
   // Exception states
   // ---------------------------------------------------------------
   // Per-exception tracker, outputs come from its state flops.
   eam_exc_state #(
      .NUM_EXC(NUM_EXC)
   ) u_exc (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .irq_hw_i(irq_hw_i),
      .irq_sw_i(irq_sw_i),
      .take_i(exc_take_i),
      .done_i(exc_done_i),
      .pending_o(exc_pending_o),
      .active_o(exc_active_o)
   );

   // Outputs straight from registers.
   assign local_tag_o = local_tag_ff;
   assign tag_addr_o = tag_addr_ff;
   assign tag_size_o = tag_size_ff;
   assign global_tag_o = gtag_ff;
   assign store_done_o = store_done_ff;
   assign store_fail_o = store_fail_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Own load without exception sets the local tag next cycle.
   a_load_sets_tag: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R01
      do_load && own_op && !exc_any |=> local_tag_o)
      else $error("Local tag not set after exclusive load.");

   // Load sets the issuer's global tag.
   a_global_tag_set: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R02
      do_load && !exc_any |=> global_tag_o[$past(op_cpu_i)])
      else $error("Global tag not set after exclusive load.");

   // Clear exclusive drops the local tag.
   a_clear_drops_tag: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R03
      do_clear && own_op |=> !local_tag_o)
      else $error("Local tag survived clear exclusive.");

   // Any own store drops the local tag.
   a_store_drops_tag: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R04
      do_store && own_op |=> !local_tag_o)
      else $error("Local tag survived exclusive store.");

   // An exception drops the local tag and own global tag.
   a_exc_drops_tags: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R05
      exc_any |=> !local_tag_o && !global_tag_o[0])
      else $error("Tags survived an exception.");

   // Clear exclusive keeps global tags unchanged.
   a_clear_keeps_global: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R06
      do_clear && !exc_any |=> $stable(global_tag_o))
      else $error("Clear exclusive changed a global tag.");

   // Store result: success only with valid tags, pulse one cycle.
   sequence s_store_issue;
      do_store && !exc_any && own_op && store_ok;
   endsequence
   a_store_status: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R08
      s_store_issue |=> store_done_o && !store_fail_o ##1 !store_done_o || $past(do_store))
      else $error("Store exclusive status wrong.");

   // Any request moves every inactive exception it names to pending next cycle.
   a_irq_pending: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R12
      |((irq_hw_i | irq_sw_i) & ~exc_pending_o & ~exc_active_o)
      |=> &(exc_pending_o | ~$past((irq_hw_i | irq_sw_i) & ~exc_pending_o & ~exc_active_o)))
      else $error("Interrupt request did not set pending.");

   // One state at a time.
   a_exc_one_state: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R10
      (exc_pending_o & exc_active_o) == '0)
      else $error("Exception in two states.");

   // Pending holds until the core services it.
   a_pending_holds: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R11
      |(exc_pending_o & ~exc_take_i)
      |=> &(exc_pending_o | ~$past(exc_pending_o & ~exc_take_i)))
      else $error("Pending exception lost without service.");

   // After reset the tag is clear and exceptions inactive.
   a_reset_state: assert property (@(posedge clk_sys_i) // R13
      srst_i |=> !local_tag_o && exc_pending_o == '0 && exc_active_o == '0)
      else $error("Reset state wrong.");

   // Reset also leaves no global tag and no store result standing.
   a_reset_clears_all: assert property (@(posedge clk_sys_i) // R13
      srst_i |=> global_tag_o == '0 && !store_done_o && !store_fail_o)
      else $error("Reset left a tag or store result.");

   // An exception in the same cycle swallows the store and its status pulse.
   a_exc_blocks_store: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R05
      exc_any |=> !store_done_o)
      else $error("Store reported although an exception was taken.");

   // Clear from another processor leaves the local tag as it was.
   a_other_clear_ignored: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R06
      do_clear && !own_op && !exc_any |=> $stable(local_tag_o))
      else $error("Foreign clear changed the local tag.");

   // An own store without a matching tag reports failure.
   a_store_fail_status: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R08
      do_store && own_op && !exc_any && !store_ok |=> store_done_o && store_fail_o)
      else $error("Untagged store did not report failure.");

   // An own load records its address and access size.
   a_load_records_size: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R09
      do_load && own_op && !exc_any
      |=> tag_addr_o == $past(op_addr_i) && tag_size_o == $past(op_size(op_code_i)))
      else $error("Load did not record address or size.");

   // Handler return leaves every returning exception inactive.
   a_done_returns: assert property (@(posedge clk_sys_i) disable iff (srst_i) // R10
      |(exc_active_o & exc_done_i)
      |=> (exc_active_o & $past(exc_active_o & exc_done_i)) == '0)
      else $error("Exception stayed active after return.");

endmodule

`default_nettype wire

// file: dv/eam_core_model.sv
// Model of the software threads and second processor that issue exclusive operations.
`timescale 1ns/1ps
`default_nettype none

module eam_core_model
   import eam_pkg::*;
(
   input wire logic clk_sys_i,
   output logic op_valid_o,
   output logic [OP_W-1:0] op_code_o,
   output logic [31:0] op_addr_o,
   output logic [0:0] op_cpu_o
);

   // ---------------------------------------------------------------
   // Operation driver
   // ---------------------------------------------------------------
   // The bus starts idle with no operation offered.
   initial begin
      op_valid_o = 1'b0;
      op_code_o = OP_NONE;
      op_addr_o = 32'h0;
      op_cpu_o = 1'b0;
   end

   // Offers one operation at the next rising edge from a falling edge and leaves it up,
   // so back-to-back calls never set a line twice at one instant; idle withdraws it.
   // Software only counts a semaphore as claimed from the returned status.
   task automatic issue(input logic [OP_W-1:0] code, input logic [31:0] addr,
                        input logic [0:0] cpu);
      op_valid_o = 1'b1;
      op_code_o = code;
      op_addr_o = addr;
      op_cpu_o = cpu;
      @(negedge clk_sys_i);
   endtask

   // Withdraws the offer; address and CPU lines show the inverse so a stale value is never reused.
   task automatic idle();
      op_valid_o = 1'b0;
      op_code_o = OP_NONE;
      op_addr_o = ~op_addr_o;
      op_cpu_o = ~op_cpu_o;
   endtask

endmodule

`default_nettype wire

// file: dv/eam_monitor_bench.sv
// Self-checking bench for the exclusive access monitor.
`timescale 1ns/1ps
`default_nettype none

module eam_monitor_bench;
   import eam_pkg::*;

   // ---------------------------------------------------------------
   // Clock, reset and design signals
   // ---------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] irq_hw = 8'h0;
   logic [7:0] irq_sw = 8'h0;
   logic [7:0] exc_take = 8'h0;
   logic [7:0] exc_done = 8'h0;
   wire logic op_valid;
   wire logic [OP_W-1:0] op_code;
   wire logic [31:0] op_addr;
   wire logic [0:0] op_cpu;
   logic local_tag;
   logic [31:0] tag_addr;
   logic [1:0] tag_size;
   logic [1:0] global_tag;
   logic store_done;
   logic store_fail;
   logic [7:0] pend;
   logic [7:0] act;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [31:0] ADDR_A = 32'h2000_0100;

   // The clock toggles every half period of 2 ns.
   always #2 clk_sys_i = ~clk_sys_i;

   eam_core_model i_core (
      .clk_sys_i(clk_sys_i),
      .op_valid_o(op_valid),
      .op_code_o(op_code),
      .op_addr_o(op_addr),
      .op_cpu_o(op_cpu)
   );

   eam_monitor #(.ADDR_W(32), .NUM_CPU(2), .CPU_W(1), .NUM_EXC(8)) i_dut (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .op_valid_i(op_valid),
      .op_code_i(op_code),
      .op_addr_i(op_addr),
      .op_cpu_i(op_cpu),
      .irq_hw_i(irq_hw),
      .irq_sw_i(irq_sw),
      .exc_take_i(exc_take),
      .exc_done_i(exc_done),
      .local_tag_o(local_tag),
      .tag_addr_o(tag_addr),
      .tag_size_o(tag_size),
      .global_tag_o(global_tag),
      .store_done_o(store_done),
      .store_fail_o(store_fail),
      .exc_pending_o(pend),
      .exc_active_o(act)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   // Compares one value and reports a difference at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Pulses exception inputs for one rising edge; the leading wait keeps a line from
   // being set twice at one falling edge.
   task automatic exc_pulse(input logic [7:0] hw, input logic [7:0] sw,
                            input logic [7:0] tk, input logic [7:0] dn);
      @(negedge clk_sys_i);
      irq_hw = hw;
      irq_sw = sw;
      exc_take = tk;
      exc_done = dn;
      @(negedge clk_sys_i);
      irq_hw = 8'h0;
      irq_sw = 8'h0;
      exc_take = 8'h0;
      exc_done = 8'h0;
   endtask

   // A hang is cut short after far more cycles than the tests need.
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_mismatch++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Checks the state straight after reset.
   task automatic t_reset();
      chk(local_tag, 1'b0);
      chk(global_tag, 2'h0);
      chk(tag_size, SIZE_WORD);
      chk(pend, 8'h0);
      chk(act, 8'h0);
      chk(store_done, 1'b0);
   endtask

   // Back-to-back loads of every size set the tags and record size and address.
   task automatic t_loads();
      logic [2:0] codes [3] = '{OP_LOAD_EXCLUSIVE_WORD, OP_LOAD_EXCLUSIVE_HALF,
                                OP_LOAD_EXCLUSIVE_BYTE};
      logic [1:0] sizes [3] = '{SIZE_WORD, SIZE_HALF, SIZE_BYTE};
      for (int i = 0; i < 3; i++) begin
         i_core.issue(codes[i], ADDR_A + 32'(i), 1'b0);
         chk(local_tag, 1'b1);
         chk(tag_addr, ADDR_A + 32'(i));
         chk(tag_size, sizes[i]);
         chk(global_tag, 2'h1);
      end
   endtask

   // Every store kind succeeds after a load; a store with no tag fails.
   task automatic t_stores();
      logic [2:0] codes [3] = '{OP_STORE_EXCLUSIVE_WORD, OP_STORE_EXCLUSIVE_HALF,
                                OP_STORE_EXCLUSIVE_BYTE};
      for (int i = 0; i < 3; i++) begin
         i_core.issue(OP_LOAD_EXCLUSIVE_WORD, ADDR_A, 1'b0);
         i_core.issue(codes[i], ADDR_A, 1'b0);
         chk({store_done, store_fail}, 2'h2);
         chk(local_tag, 1'b0);
         chk(global_tag, 2'h0);
      end
      i_core.issue(OP_STORE_EXCLUSIVE_WORD, ADDR_A, 1'b0);
      chk({store_done, store_fail}, 2'h3);
      chk(local_tag, 1'b0);
      i_core.idle();
      @(negedge clk_sys_i);
      chk(store_done, 1'b0);
   endtask

   // Clear drops the local tag only, so a later store fails.
   task automatic t_clear();
      i_core.issue(OP_LOAD_EXCLUSIVE_HALF, ADDR_A, 1'b0);
      i_core.issue(OP_CLEAR_EXCLUSIVE, ADDR_A, 1'b1);
      chk(local_tag, 1'b1);
      i_core.issue(OP_CLEAR_EXCLUSIVE, ADDR_A, 1'b0);
      chk(local_tag, 1'b0);
      chk(global_tag, 2'h1);
      i_core.issue(OP_STORE_EXCLUSIVE_HALF, ADDR_A, 1'b0);
      chk({store_done, store_fail}, 2'h3);
   endtask

   // Two processors race for one location; the first store wins.
   task automatic t_multi();
      i_core.issue(OP_LOAD_EXCLUSIVE_WORD, ADDR_A, 1'b0);
      i_core.issue(OP_LOAD_EXCLUSIVE_WORD, ADDR_A, 1'b1);
      chk(global_tag, 2'h3);
      i_core.issue(OP_STORE_EXCLUSIVE_WORD, ADDR_A, 1'b1);
      chk({store_done, store_fail}, 2'h2);
      chk(global_tag, 2'h0);
      i_core.issue(OP_STORE_EXCLUSIVE_WORD, ADDR_A, 1'b0);
      chk({store_done, store_fail}, 2'h3);
      i_core.idle();
   endtask

   // Requests go pending; a taken exception aborts a store and clears the tags.
   task automatic t_exc();
      exc_pulse(8'h02, 8'h0, 8'h0, 8'h0);
      chk(pend, 8'h02);
      exc_pulse(8'h0, 8'h04, 8'h0, 8'h0);
      chk(pend, 8'h06);
      i_core.issue(OP_LOAD_EXCLUSIVE_BYTE, ADDR_A, 1'b0);
      exc_take = 8'h02;
      i_core.issue(OP_STORE_EXCLUSIVE_BYTE, ADDR_A, 1'b0);
      exc_take = 8'h0;
      i_core.idle();
      chk(store_done, 1'b0);
      chk(local_tag, 1'b0);
      chk(global_tag, 2'h0);
      chk({pend, act}, 16'h0402);
      exc_pulse(8'h0, 8'h0, 8'h0, 8'h02);
      chk({pend, act}, 16'h0400);
      exc_pulse(8'h0, 8'h0, 8'h04, 8'h0);
      exc_pulse(8'h0, 8'h0, 8'h0, 8'h04);
      chk({pend, act}, 16'h0000);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   // Reset is held for 12 cycles and released at a falling edge.
   initial begin
      repeat (12) @(negedge clk_sys_i);
      srst_i = 1'b0;
      t_reset();
      t_loads();
      t_stores();
      t_clear();
      t_multi();
      t_exc();
      close_out();
   end

endmodule

`default_nettype wire
